// ---- hdl/bipw_device.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bipw_map.svh"
// How it works
// - One clock feeds every register
// - High reset returns unit to start
// - High enable advances, low enable stalls
// - Caller requests, unit pulses inputs accepted
// - Unit raises complete when outputs finish
// - Grant releases completion; quiescent when empty
// - Fixed initiation interval; zero means unpipelined
// - Streams obey active-low empty and full
// - Output bus carries its own valid strobe
// - Bidir takes input, returns strobed output
module bipw_device
  import bipw_pkg::*;
(
  bipw_if.device_end             bus,        // Handshake, data and memory lines
  output logic [`BIPW_CNT_W-1:0] call_count  // Calls completed since reset
);

  // ==========================================================
  // State and output registers
  bipw_state_t             state_reg;
  bipw_state_t             state_next;
  logic                    ready_reg;
  logic                    done_reg;
  logic                    idle_reg;
  logic [`BIPW_DATA_W-1:0] arg_reg;
  logic [`BIPW_DATA_W-1:0] bidir_reg;
  logic [`BIPW_DATA_W-1:0] sum_reg;
  logic [`BIPW_DATA_W-1:0] old_reg;
  logic [`BIPW_ADDR_W-1:0] addr_reg;
  logic                    mce_reg;
  logic                    mwe_reg;
  logic [`BIPW_DATA_W-1:0] mwd_reg;
  logic                    rd_en_reg;
  logic                    wr_en_reg;
  logic [`BIPW_DATA_W-1:0] sout_reg;
  logic [`BIPW_DATA_W-1:0] res_reg;
  logic                    res_vld_reg;
  logic [`BIPW_DATA_W-1:0] bido_reg;
  logic                    bido_vld_reg;
  logic [`BIPW_CNT_W-1:0]  count_reg;
  logic                    adv;

  // Every register below advances only on this term
  assign adv = bus.unit_enable;

  // Three-way sum of stream word, stored word and bidir argument
  function automatic logic [`BIPW_DATA_W-1:0] sum3(
    input logic [`BIPW_DATA_W-1:0] a,
    input logic [`BIPW_DATA_W-1:0] b,
    input logic [`BIPW_DATA_W-1:0] c
  );
    sum3 = a + b + c;
  endfunction

  // ==========================================================
  // Call sequencer
  // No overlap of calls: a new request waits for the grant
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (bus.call_request) begin
          state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (bus.sin_empty_n) begin
          state_next = ST_TAKE;
        end
      end
      ST_TAKE: begin
        state_next = ST_PUT;
      end
      ST_PUT: begin
        if (bus.sout_full_n) begin
          state_next = ST_FIN;
        end
      end
      ST_FIN: begin
        state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (bus.proceed_grant) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register, synchronous high reset
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      state_reg <= ST_IDLE;
    end else if (adv) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Block handshake outputs
  // Ready is a one-cycle pulse; done stands until the grant
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      ready_reg <= 1'h0;
      done_reg  <= 1'h0;
      idle_reg  <= 1'h1;
    end else if (adv) begin
      ready_reg <= (state_reg == ST_IDLE) && bus.call_request;
      if (state_reg == ST_IDLE && bus.call_request) begin
        idle_reg <= 1'h0;
      end
      if (state_reg == ST_FIN) begin
        done_reg <= 1'h1;
      end else if (state_reg == ST_HOLD && bus.proceed_grant) begin
        done_reg <= 1'h0;
        idle_reg <= 1'h1;
      end
    end
  end

  // ==========================================================
  // Argument capture at acceptance
  // Inputs are sampled once, so the caller may change them after ready
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      arg_reg   <= `BIPW_WORD_RST;
      bidir_reg <= `BIPW_WORD_RST;
    end else if (adv && state_reg == ST_IDLE && bus.call_request) begin
      arg_reg   <= bus.arg_in;
      bidir_reg <= bus.bidir_in;
    end
  end

  // ==========================================================
  // Single-port memory port
  // Read at acceptance, write the sum back at the same address
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      addr_reg <= '0;
      mce_reg  <= 1'h0;
      mwe_reg  <= 1'h0;
      mwd_reg  <= `BIPW_WORD_RST;
    end else if (adv) begin
      if (state_reg == ST_IDLE && bus.call_request) begin
        addr_reg <= bus.arg_in[`BIPW_ADDR_W-1:0];
        mce_reg  <= 1'h1;
      end else if (state_reg == ST_FETCH && bus.sin_empty_n) begin
        mce_reg <= 1'h0;
      end else if (state_reg == ST_PUT && bus.sout_full_n) begin
        mce_reg <= 1'h1;
        mwe_reg <= 1'h1;
        mwd_reg <= sum_reg;
      end else if (state_reg == ST_FIN) begin
        mce_reg <= 1'h0;
        mwe_reg <= 1'h0;
      end
    end
  end

  // ==========================================================
  // Stream ports and arithmetic
  // Read data is sampled at the edge that pops the input word
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      rd_en_reg <= 1'h0;
      wr_en_reg <= 1'h0;
      sum_reg   <= `BIPW_WORD_RST;
      old_reg   <= `BIPW_WORD_RST;
      sout_reg  <= `BIPW_WORD_RST;
    end else if (adv) begin
      rd_en_reg <= (state_reg == ST_FETCH) && bus.sin_empty_n;
      wr_en_reg <= (state_reg == ST_PUT) && bus.sout_full_n;
      if (state_reg == ST_TAKE) begin
        sum_reg <= sum3(bus.sin_data, bus.mem_rdata, bidir_reg);
        old_reg <= bus.mem_rdata;
      end
      if (state_reg == ST_PUT && bus.sout_full_n) begin
        sout_reg <= sum_reg;
      end
    end
  end

  // ==========================================================
  // Strobed outputs
  // Strobes stand for exactly one advancing cycle
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      res_reg      <= `BIPW_WORD_RST;
      res_vld_reg  <= 1'h0;
      bido_reg     <= `BIPW_WORD_RST;
      bido_vld_reg <= 1'h0;
    end else if (adv) begin
      res_vld_reg  <= (state_reg == ST_PUT) && bus.sout_full_n;
      bido_vld_reg <= (state_reg == ST_PUT) && bus.sout_full_n;
      if (state_reg == ST_PUT && bus.sout_full_n) begin
        res_reg  <= sum_reg;
        bido_reg <= old_reg;
      end
    end
  end

  // ==========================================================
  // Completed-call counter, wraps silently
  always_ff @(posedge bus.clk) begin
    if (bus.unit_reset) begin
      count_reg <= '0;
    end else if (adv && state_reg == ST_FIN) begin
      count_reg <= count_reg + 1'h1;
    end
  end

  // ==========================================================
  // Output wiring, all from registers
  // Initiation interval is zero: one call at a time
  assign bus.inputs_accepted = ready_reg;
  assign bus.call_complete   = done_reg;
  assign bus.unit_quiescent  = idle_reg;
  assign bus.res_out         = res_reg;
  assign bus.res_valid       = res_vld_reg;
  assign bus.bidir_out       = bido_reg;
  assign bus.bidir_valid     = bido_vld_reg;
  assign bus.sin_rd_en       = rd_en_reg;
  assign bus.sout_wr_en      = wr_en_reg;
  assign bus.sout_data       = sout_reg;
  assign bus.mem_addr        = addr_reg;
  assign bus.mem_ce          = mce_reg;
  assign bus.mem_we          = mwe_reg;
  assign bus.mem_wdata       = mwd_reg;
  assign call_count          = count_reg;

endmodule
`default_nettype wire

// ---- hdl/bipw_map.svh ----
`ifndef BIPW_MAP_SVH
`define BIPW_MAP_SVH
// ==========================================================
// Widths and sizes
`define BIPW_DATA_W    32
`define BIPW_ADDR_W    4
`define BIPW_MEM_DEPTH 16
`define BIPW_CNT_W     8
`define BIPW_BUF_DEPTH 2'h2
`define BIPW_BUF_CW    2
`define BIPW_PADDR_W   8
// ==========================================================
// Timing of one call (edges from acceptance to done; 0 = not pipelined)
`define BIPW_LATENCY   4
`define BIPW_II        0
// ==========================================================
// Caller register offsets
`define BIPW_OFF_CTRL  8'h00
`define BIPW_OFF_STAT  8'h04
`define BIPW_OFF_ARG   8'h08
`define BIPW_OFF_BIDI  8'h0c
`define BIPW_OFF_RES   8'h10
`define BIPW_OFF_BIDO  8'h14
`define BIPW_OFF_SIN   8'h18
`define BIPW_OFF_SOUT  8'h1c
// ==========================================================
// Control and status bit positions
`define BIPW_CTRL_START 0
`define BIPW_CTRL_CONT  1
`define BIPW_CTRL_EN    2
`define BIPW_CTRL_RST   3
`define BIPW_CTRL_AUTO  4
`define BIPW_ST_IDLE    0
`define BIPW_ST_DONE    1
`define BIPW_ST_START   2
`define BIPW_ST_INFULL  3
`define BIPW_ST_CNT_LO  4
`define BIPW_ST_CNT_HI  5
// ==========================================================
// Reset values
`define BIPW_EN_RST    1'h1
`define BIPW_RST_RST   1'h1
`define BIPW_WORD_RST  32'h0000_0000
`endif

// ---- hdl/bipw_pkg.sv ----
package bipw_pkg;
  // Call sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_TAKE,
    ST_PUT,
    ST_FIN,
    ST_HOLD
  } bipw_state_t;
endpackage

// ---- hdl/bipw_if.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bipw_map.svh"
// ==========================================================
// Link between the caller and the embedded unit
interface bipw_if (
  input wire logic clk  // Shared clock of both ends
);
  logic                      unit_reset;
  logic                      unit_enable;
  logic                      call_request;
  logic                      inputs_accepted;
  logic                      call_complete;
  logic                      unit_quiescent;
  logic                      proceed_grant;
  logic [`BIPW_DATA_W-1:0]   arg_in;
  logic [`BIPW_DATA_W-1:0]   res_out;
  logic                      res_valid;
  logic [`BIPW_DATA_W-1:0]   bidir_in;
  logic [`BIPW_DATA_W-1:0]   bidir_out;
  logic                      bidir_valid;
  logic                      sin_empty_n;
  logic                      sin_rd_en;
  logic [`BIPW_DATA_W-1:0]   sin_data;
  logic                      sout_full_n;
  logic                      sout_wr_en;
  logic [`BIPW_DATA_W-1:0]   sout_data;
  logic [`BIPW_ADDR_W-1:0]   mem_addr;
  logic                      mem_ce;
  logic                      mem_we;
  logic [`BIPW_DATA_W-1:0]   mem_wdata;
  logic [`BIPW_DATA_W-1:0]   mem_rdata;

  modport device_end (
    input  clk, unit_reset, unit_enable, call_request, proceed_grant,
    input  arg_in, bidir_in, sin_empty_n, sin_data, sout_full_n, mem_rdata,
    output inputs_accepted, call_complete, unit_quiescent, res_out, res_valid,
    output bidir_out, bidir_valid, sin_rd_en, sout_wr_en, sout_data,
    output mem_addr, mem_ce, mem_we, mem_wdata
  );
  modport caller_end (
    input  clk, inputs_accepted, call_complete, unit_quiescent, res_out, res_valid,
    input  bidir_out, bidir_valid, sin_rd_en, sout_wr_en, sout_data,
    input  mem_addr, mem_ce, mem_we, mem_wdata,
    output unit_reset, unit_enable, call_request, proceed_grant,
    output arg_in, bidir_in, sin_empty_n, sin_data, sout_full_n, mem_rdata
  );
endinterface
`default_nettype wire

// ---- hdl/bipw_caller.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bipw_map.svh"
module bipw_caller
  import bipw_pkg::*;
(
  input  wire logic                     pclk,     // Bus and unit clock
  input  wire logic                     presetn,  // Async reset, low
  input  wire logic [`BIPW_PADDR_W-1:0] paddr,    // APB address
  input  wire logic                     psel,     // APB select
  input  wire logic                     penable,  // APB access phase
  input  wire logic                     pwrite,   // APB write
  input  wire logic [`BIPW_DATA_W-1:0]  pwdata,   // APB write data
  output logic [`BIPW_DATA_W-1:0]       prdata,   // APB read data
  output logic                          pready,   // APB ready
  output logic                          pslverr,  // APB error
  bipw_if.caller_end                    bus       // Link to the unit
);

  // ==========================================================
  // Registers
  logic                    en_reg, rst_reg, urst_reg, auto_reg;
  logic                    start_reg, grant_reg;
  logic [`BIPW_DATA_W-1:0] arg_reg, bidi_reg, res_reg, bido_reg;
  logic [`BIPW_DATA_W-1:0] sin_reg, mrd_reg, prdata_reg, rd_mux;
  logic                    sin_full_reg, full_n_reg, pready_reg, pslverr_reg;
  logic [`BIPW_DATA_W-1:0] mem [`BIPW_MEM_DEPTH];
  logic [`BIPW_DATA_W-1:0] buf_q [2];
  logic                    wp_reg, rp_reg;
  logic [`BIPW_BUF_CW-1:0] cnt_reg, cnt_next;
  logic                    done_acc, wr_acc, rd_acc, push, pop, hit_any;

  function automatic logic hit(input logic [`BIPW_PADDR_W-1:0] a,
                               input logic [`BIPW_PADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // APB completion strobes; zero wait states
  assign done_acc = psel && penable && pready_reg;
  assign wr_acc   = done_acc && pwrite;
  assign rd_acc   = done_acc && !pwrite;
  assign hit_any  = hit(paddr, `BIPW_OFF_CTRL) || hit(paddr, `BIPW_OFF_STAT) ||
                    hit(paddr, `BIPW_OFF_ARG) || hit(paddr, `BIPW_OFF_BIDI) ||
                    hit(paddr, `BIPW_OFF_RES) || hit(paddr, `BIPW_OFF_BIDO) ||
                    hit(paddr, `BIPW_OFF_SIN) || hit(paddr, `BIPW_OFF_SOUT);

  // Read mux, unmapped reads zero
  always_comb begin
    rd_mux = '0;
    if (hit(paddr, `BIPW_OFF_CTRL)) begin
      rd_mux[`BIPW_CTRL_START] = start_reg;
      rd_mux[`BIPW_CTRL_CONT]  = grant_reg;
      rd_mux[`BIPW_CTRL_EN]    = en_reg;
      rd_mux[`BIPW_CTRL_RST]   = rst_reg;
      rd_mux[`BIPW_CTRL_AUTO]  = auto_reg;
    end else if (hit(paddr, `BIPW_OFF_STAT)) begin
      rd_mux[`BIPW_ST_IDLE]   = bus.unit_quiescent;
      rd_mux[`BIPW_ST_DONE]   = bus.call_complete;
      rd_mux[`BIPW_ST_START]  = start_reg;
      rd_mux[`BIPW_ST_INFULL] = sin_full_reg;
      rd_mux[`BIPW_ST_CNT_HI:`BIPW_ST_CNT_LO] = cnt_reg;
    end else if (hit(paddr, `BIPW_OFF_ARG)) begin
      rd_mux = arg_reg;
    end else if (hit(paddr, `BIPW_OFF_BIDI)) begin
      rd_mux = bidi_reg;
    end else if (hit(paddr, `BIPW_OFF_RES)) begin
      rd_mux = res_reg;
    end else if (hit(paddr, `BIPW_OFF_BIDO)) begin
      rd_mux = bido_reg;
    end else if (hit(paddr, `BIPW_OFF_SOUT)) begin
      rd_mux = (cnt_reg != '0) ? buf_q[rp_reg] : '0;
    end
  end

  // ==========================================================
  // APB slave answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'h0;
      prdata_reg  <= `BIPW_WORD_RST;
      pslverr_reg <= 1'h0;
    end else if (psel && !penable) begin
      pready_reg  <= 1'h1;
      prdata_reg  <= rd_mux;
      pslverr_reg <= !hit_any;
    end else if (done_acc) begin
      pready_reg  <= 1'h0;
      pslverr_reg <= 1'h0;
    end
  end

  // ==========================================================
  // Control, handshake requests; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg    <= `BIPW_EN_RST;
      rst_reg   <= 1'h0;
      urst_reg  <= `BIPW_RST_RST;
      auto_reg  <= 1'h0;
      start_reg <= 1'h0;
      grant_reg <= 1'h0;
    end else begin
      urst_reg <= rst_reg;
      if (wr_acc && hit(paddr, `BIPW_OFF_CTRL)) begin
        en_reg   <= pwdata[`BIPW_CTRL_EN];
        rst_reg  <= pwdata[`BIPW_CTRL_RST];
        auto_reg <= pwdata[`BIPW_CTRL_AUTO];
      end
      // Start held until the unit accepts it
      if (wr_acc && hit(paddr, `BIPW_OFF_CTRL) && pwdata[`BIPW_CTRL_START]) begin
        start_reg <= 1'h1;
      end else if (bus.inputs_accepted && en_reg) begin
        start_reg <= 1'h0;
      end
      if ((wr_acc && hit(paddr, `BIPW_OFF_CTRL) && pwdata[`BIPW_CTRL_CONT]) || auto_reg) begin
        grant_reg <= 1'h1;
      end else if (bus.call_complete && grant_reg && en_reg) begin
        grant_reg <= 1'h0;
      end
    end
  end

  // ==========================================================
  // Arguments, input stream word and captured strobed outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg_reg      <= `BIPW_WORD_RST;
      bidi_reg     <= `BIPW_WORD_RST;
      sin_reg      <= `BIPW_WORD_RST;
      sin_full_reg <= 1'h0;
      res_reg      <= `BIPW_WORD_RST;
      bido_reg     <= `BIPW_WORD_RST;
    end else begin
      if (wr_acc && hit(paddr, `BIPW_OFF_ARG)) arg_reg <= pwdata;
      if (wr_acc && hit(paddr, `BIPW_OFF_BIDI)) bidi_reg <= pwdata;
      // Writing while full is dropped, so no word is overwritten
      if (wr_acc && hit(paddr, `BIPW_OFF_SIN) && !sin_full_reg) begin
        sin_reg      <= pwdata;
        sin_full_reg <= 1'h1;
      end else if (bus.sin_rd_en && en_reg && sin_full_reg) begin
        sin_full_reg <= 1'h0;
      end
      if (bus.res_valid && en_reg) res_reg <= bus.res_out;
      if (bus.bidir_valid && en_reg) bido_reg <= bus.bidir_out;
    end
  end

  // ==========================================================
  // Two-entry output buffer; full flag reaches the unit
  assign push = bus.sout_wr_en && en_reg && (cnt_reg != `BIPW_BUF_DEPTH);
  assign pop  = rd_acc && hit(paddr, `BIPW_OFF_SOUT) && (cnt_reg != '0);
  assign cnt_next = cnt_reg + {1'h0, push} - {1'h0, pop};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg     <= 1'h0;
      rp_reg     <= 1'h0;
      cnt_reg    <= '0;
      full_n_reg <= 1'h1;
      buf_q[0]   <= `BIPW_WORD_RST;
      buf_q[1]   <= `BIPW_WORD_RST;
    end else begin
      if (push) begin
        buf_q[wp_reg] <= bus.sout_data;
        wp_reg        <= !wp_reg;
      end
      if (pop) rp_reg <= !rp_reg;
      cnt_reg    <= cnt_next;
      full_n_reg <= (cnt_next != `BIPW_BUF_DEPTH);
    end
  end

  // ==========================================================
  // Single-port memory served to the unit, one-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrd_reg <= `BIPW_WORD_RST;
      for (int i = 0; i < `BIPW_MEM_DEPTH; i++) mem[i] <= `BIPW_WORD_RST;
    end else if (bus.mem_ce && en_reg) begin
      if (bus.mem_we) mem[bus.mem_addr] <= bus.mem_wdata;
      else mrd_reg <= mem[bus.mem_addr];
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign bus.unit_reset    = urst_reg;
  assign bus.unit_enable   = en_reg;
  assign bus.call_request  = start_reg;
  assign bus.proceed_grant = grant_reg;
  assign bus.arg_in        = arg_reg;
  assign bus.bidir_in      = bidi_reg;
  assign bus.sin_empty_n   = sin_full_reg;
  assign bus.sin_data      = sin_reg;
  assign bus.sout_full_n   = full_n_reg;
  assign bus.mem_rdata     = mrd_reg;

endmodule
`default_nettype wire

// ---- verif/bipw_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bipw_map.svh"
// ==========================================================
// Handshake and port checks on the unit link
module bipw_chk (
  input wire logic                    clk,              // Shared clock
  input wire logic                    unit_reset,       // High reset
  input wire logic                    unit_enable,      // Advance when high
  input wire logic                    call_request,     // Caller request
  input wire logic                    inputs_accepted,  // Accept pulse
  input wire logic                    call_complete,    // Done level
  input wire logic                    unit_quiescent,   // Idle level
  input wire logic                    proceed_grant,    // Continue level
  input wire logic [`BIPW_DATA_W-1:0] res_out,          // Result word
  input wire logic                    res_valid,        // Result strobe
  input wire logic                    bidir_valid,      // Bidir strobe
  input wire logic                    sin_empty_n,      // Input not empty
  input wire logic                    sin_rd_en,        // Pop strobe
  input wire logic                    sout_full_n,      // Output not full
  input wire logic                    sout_wr_en,       // Push strobe
  input wire logic [`BIPW_DATA_W-1:0] sout_data,        // Pushed word
  input wire logic                    mem_ce,           // Memory enable
  input wire logic                    mem_we,           // Memory write
  input wire logic [`BIPW_DATA_W-1:0] mem_wdata         // Memory write data
);
  // Unit reset is synchronous, so it also masks every check except AST_RESET_IDLE
  default clocking cb @(posedge clk); endclocking
  default disable iff (unit_reset);

  AST_ACCEPT_ONE_CYCLE: assert property (inputs_accepted && unit_enable |=> !inputs_accepted)
    else $error("accept pulse longer than one cycle");
  AST_ACCEPT_FROM_IDLE: assert property (inputs_accepted && !$past(inputs_accepted) |->
    $past(unit_quiescent) && $past(call_request)) else $error("accept without idle request");
  AST_LATENCY_FLOOR: assert property (inputs_accepted && !$past(inputs_accepted) |-> !call_complete[*4])
    else $error("done earlier than latency");
  AST_LATENCY_CEIL: assert property (inputs_accepted && !$past(inputs_accepted) |-> ##[4:60] call_complete)
    else $error("done never came");
  AST_DONE_WAITS_GRANT: assert property (call_complete && !proceed_grant |=> call_complete)
    else $error("done dropped without grant");
  AST_GRANT_TO_IDLE: assert property (call_complete && proceed_grant && unit_enable |=>
    unit_quiescent && !call_complete) else $error("grant did not return unit to idle");
  AST_STALL_HOLDS: assert property (!unit_enable |=> $stable({inputs_accepted, call_complete,
    unit_quiescent, res_valid, sin_rd_en, sout_wr_en})) else $error("outputs moved while stalled");
  AST_POP_NOT_EMPTY: assert property (sin_rd_en && unit_enable |-> sin_empty_n)
    else $error("pop from empty stream");
  AST_PUSH_NOT_FULL: assert property (sout_wr_en && unit_enable |-> sout_full_n)
    else $error("push into full stream");
  AST_RESULT_PORTS: assert property (res_valid && unit_enable |-> sout_wr_en && mem_ce && mem_we &&
    bidir_valid && sout_data == res_out && mem_wdata == res_out) else $error("result ports disagree");
  AST_RESET_IDLE: assert property (disable iff (1'b0) unit_reset |=>
    unit_quiescent && !call_complete && !inputs_accepted) else $error("reset left unit busy");
endmodule
`default_nettype wire

// ---- verif/tb_blackbox_ip_port_wrapper.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bipw_map.svh"
module tb_blackbox_ip_port_wrapper;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  call_count;
  int          checked    = 0;
  int          fail_count = 0;
  int          lat        = 0;
  int          lat_seen   = 0;

  bipw_if ifc (.clk(pclk));
  bipw_caller i_bipw_caller (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(ifc));
  bipw_device i_bipw_device (.bus(ifc), .call_count(call_count));
  bipw_chk i_bipw_chk (.clk(ifc.clk), .unit_reset(ifc.unit_reset), .unit_enable(ifc.unit_enable),
    .call_request(ifc.call_request), .inputs_accepted(ifc.inputs_accepted), .call_complete(ifc.call_complete),
    .unit_quiescent(ifc.unit_quiescent), .proceed_grant(ifc.proceed_grant), .res_out(ifc.res_out),
    .res_valid(ifc.res_valid), .bidir_valid(ifc.bidir_valid), .sin_empty_n(ifc.sin_empty_n),
    .sin_rd_en(ifc.sin_rd_en), .sout_full_n(ifc.sout_full_n), .sout_wr_en(ifc.sout_wr_en),
    .sout_data(ifc.sout_data), .mem_ce(ifc.mem_ce), .mem_we(ifc.mem_we), .mem_wdata(ifc.mem_wdata));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // Edges from accept pulse to done, measured on the link itself
  always @(posedge pclk) begin
    if (ifc.inputs_accepted === 1'b1) lat <= 1;
    else if (lat > 0 && ifc.call_complete !== 1'b1) lat <= lat + 1;
    else if (lat > 0) begin
      lat_seen <= lat;
      lat <= 0;
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, r, x);
  endtask
  task automatic wait_cnt(input logic [7:0] x);
    int n;
    n = 0;
    while (call_count !== x && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("call_count", {24'h000000, call_count}, {24'h000000, x});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    rd("ctrl", `BIPW_OFF_CTRL, 32'h0000_0004);
    rd("stat", `BIPW_OFF_STAT, 32'h0000_0001);
  endtask
  // Manual continue, then auto continue reusing the same memory word
  task automatic test_calls;
    int n;
    wr(`BIPW_OFF_SIN, 32'h0000_0005);
    wr(`BIPW_OFF_ARG, 32'h0000_0003);
    wr(`BIPW_OFF_BIDI, 32'h0000_0007);
    wr(`BIPW_OFF_CTRL, 32'h0000_0005);
    n = 0;
    while (ifc.call_complete !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    rd("stat_done", `BIPW_OFF_STAT, 32'h0000_0012);
    chk("latency", lat_seen, 32'h0000_0004);
    rd("result", `BIPW_OFF_RES, 32'h0000_000c);
    rd("bidir_out", `BIPW_OFF_BIDO, 32'h0000_0000);
    wr(`BIPW_OFF_CTRL, 32'h0000_0006);
    rd("stat_idle", `BIPW_OFF_STAT, 32'h0000_0011);
    wr(`BIPW_OFF_SIN, 32'h0000_0001);
    wr(`BIPW_OFF_BIDI, 32'h0000_0002);
    wr(`BIPW_OFF_CTRL, 32'h0000_0015);
    wait_cnt(8'h02);
    rd("result2", `BIPW_OFF_RES, 32'h0000_000f);
    rd("bidir_out2", `BIPW_OFF_BIDO, 32'h0000_000c);
    rd("stat2", `BIPW_OFF_STAT, 32'h0000_0021);
  endtask
  // Held by low enable, then by a full output buffer
  task automatic test_stall;
    wr(`BIPW_OFF_SIN, 32'h0000_0004);
    wr(`BIPW_OFF_BIDI, 32'h0000_0000);
    wr(`BIPW_OFF_CTRL, 32'h0000_0011);
    repeat (8) @(posedge pclk);
    rd("stat_stall", `BIPW_OFF_STAT, 32'h0000_002d);
    wr(`BIPW_OFF_CTRL, 32'h0000_0014);
    repeat (8) @(posedge pclk);
    chk("count_full", {24'h000000, call_count}, 32'h0000_0002);
    rd("sout1", `BIPW_OFF_SOUT, 32'h0000_000c);
    wait_cnt(8'h03);
    rd("sout2", `BIPW_OFF_SOUT, 32'h0000_000f);
    rd("sout3", `BIPW_OFF_SOUT, 32'h0000_0013);
    rd("sout_empty", `BIPW_OFF_SOUT, 32'h0000_0000);
    rd("bidir_out3", `BIPW_OFF_BIDO, 32'h0000_000f);
  endtask
  task automatic test_unit_reset;
    wr(`BIPW_OFF_CTRL, 32'h0000_000c);
    wr(`BIPW_OFF_CTRL, 32'h0000_0004);
    chk("count_rst", {24'h000000, call_count}, 32'h0000_0000);
  endtask
  task automatic test_unmapped;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h20, 32'h0000_0000, r, e);
    chk("unmapped_data", r, 32'h0000_0000);
    chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_calls();
    test_stall();
    test_unit_reset();
    test_unmapped();
    finish_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
